// >>> verilog/emu_cfg.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef EMU_CFG_SVH
`define EMU_CFG_SVH
// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define REG_CTRL     8'h00
`define REG_STATUS   8'h04
`define REG_MEM_MAP  8'h08
`define REG_IO_MAP   8'h0c
`define REG_TIMER    8'h10
`define REG_LAST     8'h14
`define REG_RAM_TOP  8'h18
`define REG_HWBRK0   8'h1c
`define REG_HWBRK1   8'h20
`define REG_BRK_EN   8'h24
`define REG_SWBRK01  8'h28
`define REG_SWBRK23  8'h2c
`define REG_TR_IDX   8'h30
`define REG_TR_DATA  8'h34
// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define CTRL_RUN     0
`define CTRL_STOP    1
`define CTRL_USRCLK  2
`define RSN_ACC      7
`define RSN_IDLE     8
`define RSN_USER     9
`define RSN_W        10
`define MAP_RST      32'h0000_0000
`define RAM_TOP_RST  16'hffff
`define TRACE_DEPTH  44
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_NS       8
`define PHI_NS       500
`define PHI_CYC      (`PHI_NS / `CLK_NS)
`define IDLE_US      250000
`define IDLE_CYC     ((`IDLE_US * 1000) / `CLK_NS)
`endif

// >>> verilog/emu_pkg.sv
// Types shared by the emulator control block.
package emu_pkg;
  // Service of one memory or I/O block.
  typedef enum logic [1:0] {
    blk_user   = 2'b00,
    blk_host   = 2'b01,
    blk_absent = 2'b10
  } blk_cfg_t;

  // Emulation run state.
  typedef enum logic {
    st_idle = 1'b0,
    st_run  = 1'b1
  } emu_state_t;
endpackage : emu_pkg

// >>> verilog/trace_buf.sv
// Circular store of the most recent machine cycles.
`timescale 1ns/1ns
`include "emu_cfg.svh"
module trace_buf
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Write side
  input  wire logic        wr_en,
  input  wire logic [31:0] wr_word,
  // Read side, index 0 is the newest entry
  input  wire logic [5:0]  rd_back,
  output logic      [31:0] rd_word
);
  logic [31:0] mem_r [`TRACE_DEPTH];
  logic [5:0]  wp_r;
  logic [6:0]  pos;
  logic [5:0]  rd_pos;

  // Oldest entry is overwritten; writes stop when the run stops.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      wp_r <= 6'h00;
    else if (wr_en)
      wp_r <= (wp_r == 6'(`TRACE_DEPTH - 1)) ? 6'h00 : wp_r + 6'h01;
  end

  // Entries carry no reset; only the pointer needs a defined value.
  always_ff @(posedge aclk)
  begin
    if (wr_en)
      mem_r[wp_r] <= wr_word;
  end

  // Back index is folded onto the ring without a divider.
  assign pos     = {1'b0, wp_r} + 7'(`TRACE_DEPTH - 1) - {1'b0, rd_back};
  assign rd_pos  = (pos >= 7'(`TRACE_DEPTH)) ? 6'(pos - 7'(`TRACE_DEPTH)) : pos[5:0];
  assign rd_word = (rd_back < 6'(`TRACE_DEPTH)) ? mem_r[rd_pos] : 32'h0000_0000;
endmodule : trace_buf

// >>> verilog/emu_ctrl.sv
// Emulator control: block map, trace, timer, breaks and host registers.
//
// Operation
// - Sixteen 4K memory blocks from upper address.
// - Sixteen 16-port I/O blocks from port address.
// - Each block configured user, host or absent.
// - Absent block access flags an access error.
// - Trace status, address, data of last 44 cycles.
// - Trace stays readable after any stop.
// - 16-bit timer counts phase-two pulses while running.
// - Capture address of last emulated instruction.
// - Interrupt-enable state readable by host.
// - Three hardware, four software break conditions.
// - Emulated processor clock runs at 2 MHz.
// - Host commands and status through registers.
// - Stop writes status into host control block.
// - Host-readable top of user RAM.
// - Two 24-bit breakpoints compared on address, status.
// - Stop after quarter second of inactivity.
//
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
`include "emu_cfg.svh"
module emu_ctrl
  import emu_pkg::*;
#(
  parameter int IDLE_CYC = `IDLE_CYC
)
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic [31:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic [31:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Processor socket side
  input  wire logic        cyc_valid,
  input  wire logic        cyc_io,
  input  wire logic        cyc_fetch,
  input  wire logic [15:0] cyc_addr,
  input  wire logic [7:0]  cyc_data,
  input  wire logic [7:0]  cyc_stat,
  input  wire logic        cpu_inte,
  input  wire logic        user_phi2,
  input  wire logic        probe_in,
  // Emulation control outputs
  output logic             emu_run,
  output logic             emu_phi2,
  output logic             route_user,
  output logic             route_host,
  output logic             host_attn
);
  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  emu_state_t  st_r;
  logic [31:0] mem_map_r, io_map_r, hwbrk0_r, hwbrk1_r, sw01_r, sw23_r;
  logic [15:0] timer_r, last_r, ram_top_r;
  logic [6:0]  brk_en_r;
  logic [5:0]  tr_idx_r;
  logic [`RSN_W-1:0] rsn_r;
  logic        usrclk_r, inte_r, attn_r, ru_r, rh_r, phi_r;
  logic [5:0]  div_r;
  logic [31:0] idle_r;
  logic        aw_hold_r, w_hold_r, bvalid_r, awready_r, wready_r, arready_r, rvalid_r;
  logic [7:0]  aw_off_r;
  logic [31:0] wd_r, rdata_r;
  logic [3:0]  ws_r;
  logic [1:0]  bresp_r, rresp_r;

  // Merge a write with byte enables.
  function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] n,
                                      input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++)
      if (s[i])
        r[i*8 +: 8] = n[i*8 +: 8];
    return r;
  endfunction : mrg

  // Configuration of one of sixteen blocks in a map word.
  function automatic blk_cfg_t blk(input logic [31:0] map, input logic [3:0] idx);
    return blk_cfg_t'(map[{idx, 1'b0} +: 2]);
  endfunction : blk

  // Offset is one of the mapped registers.
  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= `REG_TR_DATA);
  endfunction : mapped

  // ----------------------------------------------------------------------
  // Cycle decode and break conditions
  // ----------------------------------------------------------------------
  // Memory blocks use address bits 15:12, I/O blocks port bits 7:4.
  wire        running  = (st_r == st_run);
  wire        cyc_act  = running & cyc_valid;
  wire [3:0]  blk_idx  = cyc_io ? cyc_addr[7:4] : cyc_addr[15:12];
  wire blk_cfg_t cfg   = blk(cyc_io ? io_map_r : mem_map_r, blk_idx);
  wire        acc_err  = cyc_act & (cfg == blk_absent);
  wire [23:0] cyc_word = {cyc_stat, cyc_addr};
  wire [6:0]  brk_raw;
  assign brk_raw[0] = cyc_valid & (cyc_word == hwbrk0_r[23:0]);
  assign brk_raw[1] = cyc_valid & (cyc_word == hwbrk1_r[23:0]);
  assign brk_raw[2] = probe_in;

  // Software breaks stop on an instruction fetch at a chosen address.
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_sw
      wire [15:0] swa = (g < 2) ? sw01_r[(g%2)*16 +: 16] : sw23_r[(g%2)*16 +: 16];
      assign brk_raw[3+g] = cyc_valid & cyc_fetch & (cyc_addr == swa);
    end
  endgenerate

  wire [6:0]  brk_hit  = running ? (brk_raw & brk_en_r) : 7'h00;
  wire        idle_hit = running & ~cyc_valid & (idle_r >= 32'(IDLE_CYC - 1));

  // ----------------------------------------------------------------------
  // Host register access
  // ----------------------------------------------------------------------
  wire        wr_go  = aw_hold_r & w_hold_r & ~bvalid_r;
  wire        wr_ok  = wr_go & mapped(aw_off_r);
  wire        ctl_wr = wr_ok & (aw_off_r == `REG_CTRL) & ws_r[0];
  wire        start  = ctl_wr & wd_r[`CTRL_RUN] & ~running;
  wire        ustop  = running & ctl_wr & wd_r[`CTRL_STOP];
  wire        stop   = running & (|brk_hit | acc_err | idle_hit | ustop);
  wire [`RSN_W-1:0] rsn_evt = {ustop, idle_hit, acc_err, brk_hit};

  wire        aw_tk  = awvalid & awready_r;
  wire        w_tk   = wvalid & wready_r;
  wire        ar_tk  = arvalid & arready_r;
  wire        aw_nxt = wr_go ? 1'b0 : (aw_hold_r | aw_tk);
  wire        w_nxt  = wr_go ? 1'b0 : (w_hold_r | w_tk);
  wire        b_nxt  = wr_go | (bvalid_r & ~bready);
  wire        r_nxt  = ar_tk | (rvalid_r & ~rready);
  wire [7:0]  ar_off = araddr[7:0];

  // Read selection; reserved bits read as zero.
  wire [31:0] tr_word;
  wire [31:0] rd_mux =
    (ar_off == `REG_CTRL)    ? {29'h0, usrclk_r, 2'b00} :
    (ar_off == `REG_STATUS)  ? {16'h0, rsn_r, attn_r, inte_r, 3'b000, running} :
    (ar_off == `REG_MEM_MAP) ? mem_map_r :
    (ar_off == `REG_IO_MAP)  ? io_map_r :
    (ar_off == `REG_TIMER)   ? {16'h0, timer_r} :
    (ar_off == `REG_LAST)    ? {16'h0, last_r} :
    (ar_off == `REG_RAM_TOP) ? {16'h0, ram_top_r} :
    (ar_off == `REG_HWBRK0)  ? {8'h0, hwbrk0_r[23:0]} :
    (ar_off == `REG_HWBRK1)  ? {8'h0, hwbrk1_r[23:0]} :
    (ar_off == `REG_BRK_EN)  ? {25'h0, brk_en_r} :
    (ar_off == `REG_SWBRK01) ? sw01_r :
    (ar_off == `REG_SWBRK23) ? sw23_r :
    (ar_off == `REG_TR_IDX)  ? {26'h0, tr_idx_r} :
    (ar_off == `REG_TR_DATA) ? tr_word : 32'h0000_0000;

  // Bus handshake state; ready is precomputed so it comes from a flop.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {aw_hold_r, w_hold_r, bvalid_r, rvalid_r} <= 4'h0;
      {awready_r, wready_r, arready_r} <= 3'b000;
      {bresp_r, rresp_r} <= 4'h0;
    end
    else
    begin
      aw_hold_r <= aw_nxt;
      w_hold_r  <= w_nxt;
      bvalid_r  <= b_nxt;
      rvalid_r  <= r_nxt;
      awready_r <= ~aw_nxt & ~b_nxt;
      wready_r  <= ~w_nxt & ~b_nxt;
      arready_r <= ~r_nxt;
      if (wr_go)
        bresp_r <= wr_ok ? 2'b00 : 2'b10;
      if (ar_tk)
        rresp_r <= mapped(ar_off) ? 2'b00 : 2'b10;
    end
  end

  // Captured request payloads.
  always_ff @(posedge aclk)
  begin
    if (aw_tk)
      aw_off_r <= awaddr[7:0];
    if (w_tk)
      {wd_r, ws_r} <= {wdata, wstrb};
    if (ar_tk)
      rdata_r <= mapped(ar_off) ? rd_mux : 32'h0000_0000;
  end

  // Configuration registers written by software.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {mem_map_r, io_map_r} <= {`MAP_RST, `MAP_RST};
      {hwbrk0_r, hwbrk1_r, sw01_r, sw23_r} <= 128'h0;
      {brk_en_r, tr_idx_r, usrclk_r} <= 14'h0;
      ram_top_r <= `RAM_TOP_RST;
    end
    else if (wr_ok)
    begin
      unique case (aw_off_r)
        `REG_CTRL:    usrclk_r  <= ws_r[0] ? wd_r[`CTRL_USRCLK] : usrclk_r;
        `REG_MEM_MAP: mem_map_r <= mrg(mem_map_r, wd_r, ws_r);
        `REG_IO_MAP:  io_map_r  <= mrg(io_map_r, wd_r, ws_r);
        `REG_RAM_TOP: ram_top_r <= 16'(mrg({16'h0, ram_top_r}, wd_r, ws_r));
        `REG_HWBRK0:  hwbrk0_r  <= mrg(hwbrk0_r, wd_r, ws_r) & 32'h00ff_ffff;
        `REG_HWBRK1:  hwbrk1_r  <= mrg(hwbrk1_r, wd_r, ws_r) & 32'h00ff_ffff;
        `REG_BRK_EN:  brk_en_r  <= ws_r[0] ? wd_r[6:0] : brk_en_r;
        `REG_SWBRK01: sw01_r    <= mrg(sw01_r, wd_r, ws_r);
        `REG_SWBRK23: sw23_r    <= mrg(sw23_r, wd_r, ws_r);
        `REG_TR_IDX:  tr_idx_r  <= ws_r[0] ? wd_r[5:0] : tr_idx_r;
        default:      tr_idx_r  <= tr_idx_r;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Run control and stop capture
  // ----------------------------------------------------------------------
  // A stop in the cycle of a new event keeps the event: reasons only clear on start.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r   <= st_idle;
      rsn_r  <= '0;
      attn_r <= 1'b0;
    end
    else
    begin
      unique case (st_r)
        st_idle: if (start) st_r <= st_run;
        st_run:  if (stop) st_r <= st_idle;
      endcase
      rsn_r  <= (start ? '0 : rsn_r) | rsn_evt;
      attn_r <= stop | (attn_r & ~start);
    end
  end

  // Phase-two enable: internal divider or the user clock pulse.
  wire div_tick = (div_r == 6'(`PHI_CYC - 1));
  wire phi_en   = usrclk_r ? user_phi2 : div_tick;

  // Timer counts only while running and restarts at each run.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {div_r, timer_r, phi_r} <= 23'h0;
      idle_r <= 32'h0;
    end
    else
    begin
      div_r   <= div_tick ? 6'h00 : div_r + 6'h01;
      phi_r   <= running & phi_en;
      timer_r <= start ? 16'h0000 : (running & phi_en) ? timer_r + 16'h0001 : timer_r;
      idle_r  <= (!running || cyc_valid) ? 32'h0 : idle_r + 32'h1;
    end
  end

  // Per-cycle capture: routing, last fetch, interrupt enable.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {ru_r, rh_r, inte_r} <= 3'b000;
      last_r <= 16'h0000;
    end
    else
    begin
      inte_r <= cpu_inte;
      if (cyc_act)
      begin
        ru_r <= (cfg == blk_user);
        rh_r <= (cfg == blk_host);
      end
      if (cyc_act & cyc_fetch)
        last_r <= cyc_addr;
    end
  end

  // ----------------------------------------------------------------------
  // Trace store
  // ----------------------------------------------------------------------
  trace_buf u_trace
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (cyc_act),
    .wr_word ({cyc_stat, cyc_addr, cyc_data}),
    .rd_back (tr_idx_r),
    .rd_word (tr_word)
  );

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign {awready, wready, arready} = {awready_r, wready_r, arready_r};
  assign {bvalid, bresp, rvalid, rresp, rdata} = {bvalid_r, bresp_r, rvalid_r, rresp_r, rdata_r};
  assign {emu_run, emu_phi2, route_user, route_host, host_attn} =
         {running, phi_r, ru_r, rh_r, attn_r};

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  timer_counts_a: assert property (running && phi_en && !start |=>
    timer_r == $past(timer_r) + 16'h0001) else $error("timer missed a pulse");
  timer_hold_a: assert property (!running && !start |=> $stable(timer_r))
    else $error("timer moved while stopped");
  absent_stop_a: assert property (acc_err |=> !emu_run && rsn_r[`RSN_ACC])
    else $error("absent block did not stop");
  hw_break_a: assert property (running && brk_en_r[0] && brk_raw[0] |=>
    !emu_run && rsn_r[0]) else $error("hardware break missed");
  sw_break_a: assert property (running && brk_en_r[3] && brk_raw[3] |=>
    !emu_run && rsn_r[3]) else $error("software break missed");
  host_route_a: assert property (cyc_act && cfg == blk_host |=>
    route_host && !route_user) else $error("host block misrouted");
  last_fetch_a: assert property (cyc_act && cyc_fetch |=>
    last_r == $past(cyc_addr)) else $error("fetch address not kept");
  idle_stop_a: assert property (idle_hit |=> !emu_run && rsn_r[`RSN_IDLE])
    else $error("idle run not stopped");
  stop_attn_a: assert property (stop |=> host_attn)
    else $error("stop not signalled to host");
  phi_rate_a: assert property (div_tick |=> !div_tick [*8])
    else $error("phase-two divider too fast");
  bus_resp_a: assert property (ar_tk |=> rvalid)
    else $error("read not answered");

  run_c:   cover property (start ##[1:300] stop);
  hwbrk_c: cover property (running && brk_hit[0]);
  acc_c:   cover property (acc_err);
  trrd_c:  cover property (ar_tk && ar_off == `REG_TR_DATA && !running);
endmodule : emu_ctrl

// >>> testbench/socket_model.sv
// Behavioural user prototype as seen through the processor socket.
`timescale 1ns/1ns
module socket_model
(
  // Clock
  input  wire logic  aclk,
  // Socket lines
  output logic       cyc_valid,
  output logic       cyc_io,
  output logic       cyc_fetch,
  output logic [15:0] cyc_addr,
  output logic [7:0] cyc_data,
  output logic [7:0] cyc_stat,
  output logic       cpu_inte,
  output logic       user_phi2,
  output logic       probe_in
);
  // Quiet socket at time zero.
  initial
  begin
    {cyc_valid, cyc_io, cyc_fetch, cpu_inte, user_phi2, probe_in} = 6'h00;
    {cyc_addr, cyc_data, cyc_stat} = 32'h0;
  end
  // One machine cycle; the lines then show the inverse so stale values never pass.
  task automatic cycle(input logic io, input logic f, input logic [15:0] a,
                       input logic [7:0] d, input logic [7:0] s);
    cyc_valid <= 1'b1;
    {cyc_io, cyc_fetch, cyc_addr, cyc_data, cyc_stat} <= {io, f, a, d, s};
    @(posedge aclk);
    cyc_valid <= 1'b0;
    {cyc_io, cyc_fetch, cyc_addr, cyc_data, cyc_stat} <= ~{io, f, a, d, s};
    @(posedge aclk);
  endtask : cycle
  // User phase-two pulses, one clock wide with a one clock gap.
  task automatic phi2(input int n);
    repeat (n)
    begin
      user_phi2 <= 1'b1;
      @(posedge aclk);
      user_phi2 <= 1'b0;
      @(posedge aclk);
    end
  endtask : phi2
  // Interrupt enable and probe levels.
  task automatic set_pins(input logic ie, input logic pr);
    cpu_inte <= ie;
    probe_in <= pr;
  endtask : set_pins
endmodule : socket_model

// >>> testbench/tb_emulator_map_trace_break.sv
// Self-checking bench for the emulator control block.
`timescale 1ns/1ns
`include "emu_cfg.svh"
`define CHK(nm, e, g) \
  begin \
    total_checks++; \
    if ((g) !== (e)) \
    begin \
      n_mismatch++; \
      $display("unexpected %s: expected %h seen %h", nm, e, g); \
    end \
  end
module tb_emulator_map_trace_break
  import emu_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  localparam int IDLE = 50;
  logic        aclk, aresetn;
  logic [31:0] awaddr, wdata, araddr, rdata, d;
  logic [3:0]  wstrb;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp, r, wr_resp;
  logic        cyc_valid, cyc_io, cyc_fetch, cpu_inte, user_phi2, probe_in;
  logic [15:0] cyc_addr;
  logic [7:0]  cyc_data, cyc_stat;
  logic        emu_run, emu_phi2, route_user, route_host, host_attn;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          n_phi2 = 0;

  emu_ctrl #(.IDLE_CYC(IDLE)) i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .cyc_valid, .cyc_io, .cyc_fetch,
    .cyc_addr, .cyc_data, .cyc_stat, .cpu_inte, .user_phi2, .probe_in, .emu_run,
    .emu_phi2, .route_user, .route_host, .host_attn);
  socket_model i_model (.aclk, .cyc_valid, .cyc_io, .cyc_fetch, .cyc_addr,
    .cyc_data, .cyc_stat, .cpu_inte, .user_phi2, .probe_in);

  // 125 MHz clock.
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // Counts the emulated phase-two pulses that the block puts out.
  always @(posedge aclk)
  begin
    if (emu_phi2 === 1'b1)
      n_phi2 <= n_phi2 + 1;
  end
  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  // Write: address and data offered together, each dropped once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awaddr <= {24'h0, a};
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
    wr_resp = bresp;
    // One quiet edge so a following call never drives bready twice at once.
    @(posedge aclk);
  endtask : wr
  // Read: data and response taken at the edge that shows rvalid.
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rready <= 1'b0;
    v = rdata;
    e = rresp;
    @(posedge aclk);
  endtask : rd
  // Read one register and compare it.
  task automatic expect_reg(input string nm, input logic [7:0] a, input logic [31:0] e);
    rd(a, d, r);
    `CHK(nm, e, d)
  endtask : expect_reg
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset values, a writable limit and an unmapped offset.
  task automatic t_reset();
    `CHK("run_rst", 1'b0, emu_run)
    `CHK("attn_rst", 1'b0, host_attn)
    expect_reg("mem_map", `REG_MEM_MAP, 32'h0);
    expect_reg("ram_top", `REG_RAM_TOP, 32'h0000ffff);
    wr(`REG_RAM_TOP, 32'h00007fff);
    `CHK("ram_top_bresp", 2'b00, wr_resp)
    expect_reg("ram_top_w", `REG_RAM_TOP, 32'h00007fff);
    `CHK("ram_top_rresp", 2'b00, r)
    wr(8'h38, 32'h0000ffff);
    `CHK("unmapped_bresp", 2'b10, wr_resp)
    rd(8'h38, d, r);
    `CHK("unmapped_resp", 2'b10, r)
    `CHK("unmapped_data", 32'h0, d)
  endtask : t_reset
  // Memory block 3 absent, I/O block 5 host; memory block 5 stays with the user.
  task automatic t_map();
    wr(`REG_MEM_MAP, 32'h00000080);
    wr(`REG_IO_MAP, 32'h00000400);
    wr(`REG_CTRL, 32'h1);
    i_model.cycle(1'b0, 1'b1, 16'h5678, 8'h11, 8'h00);
    `CHK("route_mem5", 1'b1, route_user)
    i_model.cycle(1'b1, 1'b0, 16'h0053, 8'h22, 8'h10);
    `CHK("route_io5", 1'b1, route_host)
    i_model.cycle(1'b1, 1'b0, 16'h3033, 8'h22, 8'h10);
    `CHK("route_io3", 1'b1, route_user)
    `CHK("run_io3", 1'b1, emu_run)
    i_model.cycle(1'b0, 1'b0, 16'h3fff, 8'h33, 8'h00);
    `CHK("route_absent", 2'b00, {route_user, route_host})
    `CHK("run_absent", 1'b0, emu_run)
    `CHK("attn_absent", 1'b1, host_attn)
    expect_reg("status_absent", `REG_STATUS, 32'h00002020);
  endtask : t_map
  // Fifty cycles, user stop, then a cycle that must not enter the ring.
  task automatic t_trace();
    wr(`REG_CTRL, 32'h1);
    for (int i = 0; i < 50; i++)
      i_model.cycle(1'b0, i[0] == 1'b0, 16'h0100 + 16'(i), 8'(i), 8'(i + 128));
    `CHK("route_trace", 1'b1, route_user)
    wr(`REG_CTRL, 32'h2);
    `CHK("run_stop", 1'b0, emu_run)
    i_model.cycle(1'b0, 1'b1, 16'h0200, 8'hff, 8'hff);
    wr(`REG_TR_IDX, 32'd0);
    expect_reg("trace_new", `REG_TR_DATA, 32'hb1013131);
    wr(`REG_TR_IDX, 32'd43);
    expect_reg("trace_old", `REG_TR_DATA, 32'h86010606);
    wr(`REG_TR_IDX, 32'd44);
    expect_reg("trace_out", `REG_TR_DATA, 32'h0);
    expect_reg("last_insn", `REG_LAST, 32'h00000130);
    expect_reg("status_user", `REG_STATUS, 32'h00008020);
  endtask : t_trace
  // Timer counts user phase-two pulses only while running.
  task automatic t_timer();
    int p0;
    p0 = n_phi2;
    wr(`REG_CTRL, 32'h5);
    i_model.phi2(7);
    wr(`REG_CTRL, 32'h6);
    i_model.phi2(3);
    expect_reg("timer", `REG_TIMER, 32'd7);
    expect_reg("ctrl_src", `REG_CTRL, 32'h4);
    `CHK("phi2_pulses", 7, n_phi2 - p0)
    wr(`REG_CTRL, 32'h0);
  endtask : t_timer
  // Hardware compare needs status as well as address; then probe and software break.
  task automatic t_break();
    i_model.set_pins(1'b1, 1'b0);
    wr(`REG_HWBRK0, 32'h005a2345);
    wr(`REG_SWBRK01, 32'h00000777);
    wr(`REG_BRK_EN, 32'h0000000d);
    wr(`REG_CTRL, 32'h1);
    i_model.cycle(1'b0, 1'b0, 16'h2345, 8'h00, 8'h00);
    `CHK("run_nomatch", 1'b1, emu_run)
    i_model.cycle(1'b0, 1'b0, 16'h2345, 8'h00, 8'h5a);
    `CHK("run_hw", 1'b0, emu_run)
    expect_reg("status_hw", `REG_STATUS, 32'h00000070);
    wr(`REG_CTRL, 32'h1);
    i_model.set_pins(1'b1, 1'b1);
    repeat (3) @(posedge aclk);
    `CHK("run_probe", 1'b0, emu_run)
    i_model.set_pins(1'b1, 1'b0);
    expect_reg("status_probe", `REG_STATUS, 32'h00000130);
    wr(`REG_CTRL, 32'h1);
    i_model.cycle(1'b0, 1'b1, 16'h0777, 8'h00, 8'h00);
    `CHK("run_sw", 1'b0, emu_run)
    expect_reg("status_sw", `REG_STATUS, 32'h00000230);
    i_model.set_pins(1'b0, 1'b0);
  endtask : t_break
  // A run with no machine cycles ends after the idle span.
  task automatic t_idle();
    wr(`REG_CTRL, 32'h1);
    repeat (IDLE - 10) @(posedge aclk);
    `CHK("run_idle", 1'b1, emu_run)
    repeat (20) @(posedge aclk);
    `CHK("run_idle_end", 1'b0, emu_run)
    expect_reg("status_idle", `REG_STATUS, 32'h00004020);
  endtask : t_idle
  // Counts, verdict and end of run.
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done
  // Main sequence.
  initial
  begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, wdata, araddr} = 96'h0;
    wstrb = 4'hf;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_map();
    t_trace();
    t_timer();
    t_break();
    t_idle();
    test_done();
  end
  // Watchdog well beyond the few hundred cycles the tests need.
  initial
  begin
    #200000;
    n_mismatch++;
    test_done();
  end
endmodule : tb_emulator_map_trace_break
